// >>> sbc_pkg.sv
// Constants and types for the stack back-channel coordinator
// Contract
// RULE_01 - Strap mismatch: switches off, share low, quiet
// RULE_02 - Controller keeps modulating through sync faults
// RULE_03 - Follower sync fault: switches off, share low
// RULE_04 - Every stack member wired and configured alike
// RULE_05 - Inconsistent stack flags fault, blocks conversion
// RULE_06 - Controller verifies followers present and ordered
// RULE_07 - Controller copies four settings into followers
// RULE_08 - Only controller answers host; followers ignore
// RULE_09 - Shared setting writes forwarded to followers
// RULE_10 - Controller polls followers, keeps aggregate status
// RULE_11 - Phase select resets to all phases
// RULE_12 - Indexed phase targets matching phase_order_config order
// RULE_13 - Follower writes queued while link busy
// RULE_14 - Queued writes leave in acceptance order
// RULE_15 - Follower reads bypass queue, go first
// RULE_16 - Host waits 4 ms before follower readback
// RULE_17 - Controller initiates link, one transfer only
package sbc_pkg;
   // ------
   // Register codes
   // ------
   localparam logic [7:0] REG_PHASE = 8'h04;
   localparam logic [7:0] REG_VOUT = 8'h21;
   localparam logic [7:0] REG_FREQ = 8'h33;
   localparam logic [7:0] REG_ORDER = 8'h37;
   localparam logic [7:0] REG_RAMP = 8'h61;
   localparam logic [7:0] REG_TUNE = 8'hb1;
   localparam logic [7:0] REG_ARRANGE = 8'hec;
   localparam logic [7:0] REG_STATUS = 8'h79;
   localparam logic [7:0] PHASE_ALL = 8'hff;
   localparam logic [6:0] BCAST_IDX = 7'h7f;
   // Reset values
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [39:0] RST_TUNE = 40'h00_0000_0000;
   // ------
   // Link framing and timing
   // ------
   localparam int DATA_W = 40;
   localparam int HDR_BITS = 16;
   localparam int FRAME_BITS = 56;
   localparam int CLK_PERIOD_NS = 10;
   localparam int BC_HALF_NS = 60;
   localparam int BC_HALF_CYC = (BC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POLL_PERIOD_US = 1000;
   localparam int POLL_CYC_DEF = POLL_PERIOD_US * 1000 / CLK_PERIOD_NS;
   // ------
   // Types
   // ------
   typedef enum logic [2:0] {
      ST_STRAP = 3'b000, ST_VERIFY = 3'b001, ST_LOAD = 3'b010,
      ST_RUN = 3'b011, ST_FAULT = 3'b100
   } sbc_state_t;
   typedef enum logic [2:0] {
      OP_NONE = 3'b000, OP_SEQ = 3'b001, OP_QWR = 3'b010,
      OP_HRD = 3'b011, OP_POLL = 3'b100
   } sbc_op_t;
   typedef struct packed {
      logic wr;
      logic [7:0] code;
      logic [DATA_W-1:0] data;
   } sbc_hcmd_t;
   typedef struct packed {
      logic rd;
      logic [6:0] idx;
      logic [7:0] code;
      logic [DATA_W-1:0] data;
   } sbc_frame_t;
endpackage

// >>> sbc_top.sv
// Stack back-channel coordinator: straps, sequencing, relay, polling
`timescale 1ns/10ps
module sbc_top import sbc_pkg::*; #(
   parameter int NUM_FOL = 3,
   parameter int QDEPTH = 4,
   parameter int POLL_CYC = POLL_CYC_DEF
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic host_cmd_valid,
   input wire sbc_hcmd_t host_cmd,
   output logic host_cmd_ready,
   output logic host_rsp_valid,
   output logic [DATA_W-1:0] host_rsp_data,
   input wire logic role_follower_in,
   input wire logic straps_settled_in,
   input wire logic strap_mismatch_in,
   input wire logic sync_fault_in,
   input wire logic sync_stuck_in,
   input wire logic vout_ok_in,
   output logic backchannel_clock_o,
   output logic backchannel_clock_oe,
   input wire logic backchannel_data_i,
   output logic backchannel_data_o,
   output logic backchannel_data_oe,
   output logic switch_enable,
   output logic current_share_line_pull_low,
   output logic power_good_output,
   output logic alert_pin_o,
   output logic alert_pin_oe,
   output logic strap_mismatch_fault,
   output logic por_fault
);
   // ------
   // Input synchronisers
   // ------
   logic [6:0] raw; // Pins from other domains
   logic [6:0] meta_r; // First stage, read only by syn_r
   logic [6:0] syn_r; // Safe copies
   assign raw = {backchannel_data_i, vout_ok_in, sync_stuck_in,
      sync_fault_in, strap_mismatch_in, straps_settled_in, role_follower_in};

   // Two flops per pin
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= 7'h00;
         syn_r <= 7'h00;
      end else begin
         meta_r <= raw;
         syn_r <= meta_r;
      end
   end

   logic sync_bad; // Sync fault or stuck level
   assign sync_bad = syn_r[3] | syn_r[4];

   // ------
   // Declarations
   // ------
   sbc_state_t st_r; // Sequencer state
   logic follower_r; // Role caught from strap
   logic strap_fault_r; // Strap mismatch latched
   logic por_fault_r; // Stack programming fault
   logic [6:0] sq_fol_r; // Follower being set up
   logic [2:0] sq_item_r; // Step within follower
   logic sq_wait_r; // Sequencer op in flight
   logic [7:0] phase_r; // Phase select
   logic [15:0] vout_r, freq_r, order_r, ramp_r, arr_r;
   logic [39:0] tune_r; // Loop tuning
   logic lk_busy_r, lk_done_r, lk_hi_r, lk_start_r, lk_rd_r;
   logic [7:0] lk_div_r; // Half-period counter
   logic [5:0] lk_bit_r; // Bit in frame
   logic [FRAME_BITS-1:0] lk_sh_r; // Outgoing shifter
   logic [DATA_W-1:0] lk_rx_r; // Read data
   sbc_op_t lk_kind_r; // Owner of current transfer
   sbc_op_t grant; // Arbiter pick
   sbc_frame_t lk_frame; // Frame for grant
   logic lk_go; // Start a transfer
   sbc_frame_t q_mem [QDEPTH]; // Write queue storage
   logic [$clog2(QDEPTH)-1:0] q_wp_r, q_rp_r;
   logic [$clog2(QDEPTH):0] q_cnt_r;
   logic q_push, q_pop, q_full;
   logic hrd_pend_r, hrd_wait_r; // Host follower read
   sbc_frame_t hrd_fr_r; // Its frame
   logic [31:0] poll_cnt_r; // Poll interval timer
   logic poll_pend_r; // Poll due
   logic [6:0] poll_fol_r; // Next follower polled
   logic [15:0] stat_r [NUM_FOL]; // Polled status
   logic [15:0] stat_or; // Aggregate
   logic accept, hc_all, hc_own, hc_fol, shared, need_q;
   logic seq_req;
   sbc_frame_t seq_fr; // Sequencer frame
   sbc_frame_t push_fr; // Host frame to queue
   logic [DATA_W-1:0] loc_rd; // Local read mux

   // ------
   // Host decode
   // ------
   always_comb begin
      hc_all = (phase_r == PHASE_ALL); // see RULE_11
      hc_own = (phase_r == {4'h0, order_r[3:0]}); // see RULE_12
      hc_fol = !hc_all && !hc_own && (host_cmd.code != REG_PHASE);
      shared = (host_cmd.code == REG_VOUT) || (host_cmd.code == REG_FREQ) ||
         (host_cmd.code == REG_RAMP) || (host_cmd.code == REG_TUNE);
      // Forward shared writes or aim at one follower
      need_q = host_cmd.wr && (hc_fol || (hc_all && shared)); // see RULE_09
      q_full = (q_cnt_r == ($clog2(QDEPTH)+1)'(QDEPTH));
      push_fr.rd = 1'b0;
      push_fr.idx = hc_all ? BCAST_IDX : phase_r[6:0];
      push_fr.code = host_cmd.code;
      push_fr.data = host_cmd.data;
      // Followers never take host traffic; stall a queued write when queue full
      host_cmd_ready = (st_r == ST_RUN) && !follower_r && // see RULE_08
         !hrd_pend_r && !hrd_wait_r && !(need_q && q_full); // see RULE_13
      accept = host_cmd_valid && host_cmd_ready;
      q_push = accept && need_q;
   end

   // Local read mux
   always_comb begin
      case (host_cmd.code)
         REG_PHASE: loc_rd = {32'h0000_0000, phase_r};
         REG_VOUT: loc_rd = {24'h00_0000, vout_r};
         REG_FREQ: loc_rd = {24'h00_0000, freq_r};
         REG_ORDER: loc_rd = {24'h00_0000, order_r};
         REG_RAMP: loc_rd = {24'h00_0000, ramp_r};
         REG_TUNE: loc_rd = tune_r;
         REG_ARRANGE: loc_rd = {24'h00_0000, arr_r};
         REG_STATUS: loc_rd = {24'h00_0000, stat_or}; // see RULE_10
         default: loc_rd = '0;
      endcase
   end

   // ------
   // Register file, written when this device is targeted
   // ------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         phase_r <= PHASE_ALL; // see RULE_11
         vout_r <= RST_WORD;
         freq_r <= RST_WORD;
         order_r <= RST_WORD;
         ramp_r <= RST_WORD;
         arr_r <= RST_WORD;
         tune_r <= RST_TUNE;
      end else if (accept && host_cmd.wr) begin
         if (host_cmd.code == REG_PHASE) begin
            phase_r <= host_cmd.data[7:0];
         end else if (hc_all || hc_own) begin
            case (host_cmd.code)
               REG_VOUT: vout_r <= host_cmd.data[15:0];
               REG_FREQ: freq_r <= host_cmd.data[15:0];
               REG_ORDER: order_r <= host_cmd.data[15:0];
               REG_RAMP: ramp_r <= host_cmd.data[15:0];
               REG_TUNE: tune_r <= host_cmd.data;
               REG_ARRANGE: arr_r <= host_cmd.data[15:0];
               default: ;
            endcase
         end
      end
   end

   // ------
   // Host answers: local next cycle, follower on link done
   // ------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         host_rsp_valid <= 1'b0;
         host_rsp_data <= '0;
         hrd_pend_r <= 1'b0;
         hrd_wait_r <= 1'b0;
         hrd_fr_r <= '0;
      end else begin
         host_rsp_valid <= 1'b0;
         if (accept && !host_cmd.wr && hc_fol) begin
            hrd_pend_r <= 1'b1; // Not queued: see RULE_15
            hrd_fr_r <= '{rd: 1'b1, idx: phase_r[6:0], code: host_cmd.code, data: '0};
         end else if (accept && !host_cmd.wr) begin
            host_rsp_valid <= 1'b1;
            host_rsp_data <= loc_rd;
         end
         if (grant == OP_HRD) begin
            hrd_pend_r <= 1'b0;
            hrd_wait_r <= 1'b1;
         end
         if (lk_done_r && lk_kind_r == OP_HRD) begin
            hrd_wait_r <= 1'b0;
            host_rsp_valid <= 1'b1;
            host_rsp_data <= lk_rx_r;
         end
      end
   end

   // ------
   // Write queue, strict first in first out
   // ------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         q_wp_r <= '0;
         q_rp_r <= '0;
         q_cnt_r <= '0;
      end else begin
         if (q_push) begin
            q_wp_r <= q_wp_r + 1'b1; // see RULE_14
         end
         if (q_pop) begin
            q_rp_r <= q_rp_r + 1'b1; // see RULE_14
         end
         q_cnt_r <= q_cnt_r + q_push - q_pop;
      end
   end

   // Storage needs no reset
   always_ff @(posedge clk_sys) begin
      if (q_push) begin
         q_mem[q_wp_r] <= push_fr;
      end
   end

   // ------
   // Arbiter: setup, then host read, queue, poll
   // ------
   always_comb begin
      seq_fr.rd = (st_r == ST_VERIFY);
      seq_fr.idx = sq_fol_r;
      seq_fr.data = '0;
      case ({st_r == ST_LOAD, sq_item_r[1:0]})
         3'b000: seq_fr.code = REG_ORDER;
         3'b001: seq_fr.code = REG_ARRANGE;
         3'b100: seq_fr.code = REG_TUNE;
         3'b101: seq_fr.code = REG_FREQ;
         3'b110: seq_fr.code = REG_RAMP;
         default: seq_fr.code = REG_VOUT;
      endcase
      case (sq_item_r[1:0])
         2'b00: seq_fr.data = tune_r;
         2'b01: seq_fr.data = {24'h00_0000, freq_r};
         2'b10: seq_fr.data = {24'h00_0000, ramp_r};
         default: seq_fr.data = {24'h00_0000, vout_r};
      endcase
      seq_req = (st_r == ST_VERIFY || st_r == ST_LOAD) && !sq_wait_r;
      grant = OP_NONE;
      lk_frame = '0;
      if (!lk_busy_r) begin // see RULE_17
         if (seq_req) begin
            grant = OP_SEQ;
            lk_frame = seq_fr;
         end else if (hrd_pend_r) begin
            grant = OP_HRD; // see RULE_15
            lk_frame = hrd_fr_r;
         end else if (q_cnt_r != '0) begin
            grant = OP_QWR; // see RULE_13
            lk_frame = q_mem[q_rp_r];
         end else if (poll_pend_r) begin
            grant = OP_POLL;
            lk_frame = '{rd: 1'b1, idx: poll_fol_r, code: REG_STATUS, data: '0};
         end
      end
      lk_go = (grant != OP_NONE);
      q_pop = (grant == OP_QWR);
   end

   // ------
   // Link engine: start, then 56 bits, clock low then high
   // ------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         lk_busy_r <= 1'b0;
         lk_done_r <= 1'b0;
         lk_hi_r <= 1'b1;
         lk_start_r <= 1'b0;
         lk_rd_r <= 1'b0;
         lk_div_r <= 8'h00;
         lk_bit_r <= 6'h00;
         lk_sh_r <= '0;
         lk_rx_r <= '0;
         lk_kind_r <= OP_NONE;
         backchannel_clock_o <= 1'b1;
         backchannel_data_o <= 1'b1;
         backchannel_data_oe <= 1'b0;
      end else begin
         lk_done_r <= 1'b0;
         if (!lk_busy_r) begin
            if (lk_go) begin // Start: data low under high clock
               lk_busy_r <= 1'b1;
               lk_start_r <= 1'b1;
               lk_sh_r <= lk_frame;
               lk_rd_r <= lk_frame.rd;
               lk_kind_r <= grant;
               lk_bit_r <= 6'h00;
               lk_div_r <= 8'h00;
               backchannel_data_o <= 1'b0;
               backchannel_data_oe <= 1'b1;
            end
         end else if (lk_div_r != 8'(BC_HALF_CYC - 1)) begin
            lk_div_r <= lk_div_r + 8'h01;
         end else begin
            lk_div_r <= 8'h00;
            if (lk_start_r) begin
               lk_start_r <= 1'b0;
               lk_hi_r <= 1'b0;
               backchannel_clock_o <= 1'b0;
               backchannel_data_o <= lk_sh_r[FRAME_BITS-1];
            end else if (!lk_hi_r) begin
               lk_hi_r <= 1'b1;
               backchannel_clock_o <= 1'b1;
            end else begin
               // Sample read data late in the high half
               if (lk_rd_r && lk_bit_r >= 6'(HDR_BITS)) begin
                  lk_rx_r <= {lk_rx_r[DATA_W-2:0], syn_r[6]};
               end
               if (lk_bit_r == 6'(FRAME_BITS - 1)) begin
                  lk_busy_r <= 1'b0;
                  lk_done_r <= 1'b1;
                  backchannel_data_o <= 1'b1;
                  backchannel_data_oe <= 1'b0;
               end else begin
                  lk_bit_r <= lk_bit_r + 6'h01;
                  lk_sh_r <= {lk_sh_r[FRAME_BITS-2:0], 1'b0};
                  lk_hi_r <= 1'b0;
                  backchannel_clock_o <= 1'b0;
                  backchannel_data_o <= lk_sh_r[FRAME_BITS-2];
                  // Release data for the reply field
                  backchannel_data_oe <= !(lk_rd_r && lk_bit_r >= 6'(HDR_BITS - 1));
               end
            end
         end
      end
   end

   // Controller owns the clock line
   assign backchannel_clock_oe = !follower_r && (st_r != ST_STRAP); // see RULE_17

   // ------
   // Power-on sequencer
   // ------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= ST_STRAP;
         follower_r <= 1'b0;
         strap_fault_r <= 1'b0;
         por_fault_r <= 1'b0;
         sq_fol_r <= 7'h01;
         sq_item_r <= 3'h0;
         sq_wait_r <= 1'b0;
      end else begin
         if (grant == OP_SEQ) begin
            sq_wait_r <= 1'b1;
         end
         case (st_r)
            ST_STRAP: begin
               // Straps checked before any ramp
               if (syn_r[1]) begin
                  follower_r <= syn_r[0];
                  if (syn_r[2]) begin
                     strap_fault_r <= 1'b1; // see RULE_01
                     st_r <= ST_FAULT;
                  end else if (syn_r[0] || NUM_FOL == 0) begin
                     st_r <= ST_RUN;
                  end else begin
                     st_r <= ST_VERIFY;
                  end
               end
            end
            ST_VERIFY, ST_LOAD: begin
               if (lk_done_r && lk_kind_r == OP_SEQ) begin
                  sq_wait_r <= 1'b0;
                  // Follower must echo its order and arrangement
                  if (st_r == ST_VERIFY && ((sq_item_r == 3'h0 && // see RULE_06
                     lk_rx_r[3:0] != sq_fol_r[3:0]) ||
                     (sq_item_r == 3'h1 && lk_rx_r[15:0] != arr_r))) begin
                     por_fault_r <= 1'b1; // see RULE_05
                     st_r <= ST_FAULT;
                  end else if (sq_item_r != ((st_r == ST_VERIFY) ? 3'h1 : 3'h3)) begin
                     sq_item_r <= sq_item_r + 3'h1; // see RULE_07
                  end else begin
                     sq_item_r <= 3'h0;
                     if (sq_fol_r == 7'(NUM_FOL)) begin
                        sq_fol_r <= 7'h01;
                        st_r <= (st_r == ST_VERIFY) ? ST_LOAD : ST_RUN;
                     end else begin
                        sq_fol_r <= sq_fol_r + 7'h01;
                     end
                  end
               end
            end
            ST_RUN: ;
            ST_FAULT: ; // Held until reset
            default: st_r <= ST_FAULT;
         endcase
      end
   end

   // ------
   // Periodic polling of followers
   // ------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         poll_cnt_r <= 32'h0000_0000;
         poll_pend_r <= 1'b0;
         poll_fol_r <= 7'h01;
      end else begin
         if (grant == OP_POLL) begin
            poll_pend_r <= 1'b0;
         end else if (poll_cnt_r == 32'(POLL_CYC - 1)) begin
            poll_pend_r <= (st_r == ST_RUN) && !follower_r && NUM_FOL > 0; // see RULE_10
         end
         poll_cnt_r <= (poll_cnt_r == 32'(POLL_CYC - 1)) ? 32'h0000_0000 : poll_cnt_r + 32'h0000_0001;
         if (lk_done_r && lk_kind_r == OP_POLL) begin
            poll_fol_r <= (poll_fol_r == 7'(NUM_FOL)) ? 7'h01 : poll_fol_r + 7'h01;
         end
      end
   end

   // Per-follower status record
   for (genvar g = 0; g < NUM_FOL; g++) begin : g_stat
      always_ff @(posedge clk_sys or negedge rst_b) begin
         if (!rst_b) begin
            stat_r[g] <= 16'h0000;
         end else if (lk_done_r && lk_kind_r == OP_POLL && poll_fol_r == 7'(g + 1)) begin
            stat_r[g] <= lk_rx_r[15:0]; // see RULE_10
         end
      end
   end

   // Stack aggregate
   always_comb begin
      stat_or = 16'h0000;
      for (int i = 0; i < NUM_FOL; i++) begin
         stat_or = stat_or | stat_r[i];
      end
   end

   // ------
   // Fault responses and power outputs
   // ------
   logic fol_off; // Follower hit by sync fault
   assign fol_off = follower_r && sync_bad; // see RULE_03

   // Sync faults only stop followers, even during ramp
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         switch_enable <= 1'b0;
         current_share_line_pull_low <= 1'b0;
         power_good_output <= 1'b0;
         alert_pin_oe <= 1'b0;
      end else begin
         switch_enable <= (st_r == ST_RUN) && !fol_off; // see RULE_02
         current_share_line_pull_low <= strap_fault_r || fol_off; // see RULE_01
         power_good_output <= (st_r == ST_RUN) && !fol_off && syn_r[5];
         alert_pin_oe <= por_fault_r; // Strap mismatch stays quiet: see RULE_01
      end
   end

   assign alert_pin_o = 1'b0;
   assign strap_mismatch_fault = strap_fault_r;
   assign por_fault = por_fault_r;

   // ------
   // Assertions
   // ------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   strap_off_a: assert property (strap_fault_r |=> !switch_enable && current_share_line_pull_low
      && !power_good_output && !alert_pin_oe) else $error("strap fault response wrong"); // see RULE_01
   ctrl_sync_a: assert property (st_r == ST_RUN && !follower_r && sync_bad |=> switch_enable)
      else $error("controller stopped on sync fault"); // see RULE_02
   fol_sync_a: assert property (fol_off |=> !switch_enable && current_share_line_pull_low
      && !power_good_output) else $error("follower sync response wrong"); // see RULE_03
   por_block_a: assert property (por_fault_r |-> ##1 !switch_enable [*2])
      else $error("conversion on por fault"); // see RULE_05
   fol_host_a: assert property (follower_r |-> !host_cmd_ready)
      else $error("follower took host traffic"); // see RULE_08
   phase_rst_a: assert property (st_r != ST_RUN |-> phase_r == PHASE_ALL)
      else $error("phase select not all"); // see RULE_11
   q_grow_a: assert property (q_push && !q_pop |=> q_cnt_r == $past(q_cnt_r) + 1'b1)
      else $error("queued write lost"); // see RULE_13
   rd_first_a: assert property (!lk_busy_r && hrd_pend_r && !seq_req |-> grant == OP_HRD)
      else $error("follower read not first"); // see RULE_15
   one_xfer_a: assert property (lk_go |-> !lk_busy_r ##1 lk_busy_r)
      else $error("overlapping transfers"); // see RULE_17
   hrd_rsp_a: assert property (lk_done_r && lk_kind_r == OP_HRD |=> host_rsp_valid)
      else $error("follower read unanswered"); // see RULE_15
endmodule

// >>> sbc_fol_model.sv
// Behavioural loop followers answering on the back-channel
`timescale 1ns/10ps
module sbc_fol_model import sbc_pkg::*; (
   input wire logic bc_clk,
   input wire logic bc_line,
   input wire logic rst_b,
   input wire logic bad_arr,
   output logic dat_o,
   output logic dat_oe
);
   logic [DATA_W-1:0] mem [bit [14:0]]; // Keyed by index and code
   sbc_frame_t f;
   int wr_cnt = 0; // Write frames seen
   // Frame starts with line falling while clock high; reset aborts it
   initial begin
      dat_o = 1'b1;
      dat_oe = 1'b0;
      forever begin
         fork
            begin
               @(negedge bc_line iff bc_clk);
               for (int i = FRAME_BITS - 1; i >= 0; i--) begin
                  @(negedge bc_clk);
                  if (f.rd && i < DATA_W) begin
                     dat_oe <= 1'b1;
                     dat_o <= f.data[i];
                  end
                  @(posedge bc_clk);
                  if (!(f.rd && i < DATA_W))
                     f[i] = bc_line;
                  // Every member reports its order and a shared arrangement
                  if (i == DATA_W && f.rd)
                     f.data = (f.code == REG_ORDER) ? 40'(f.idx) : (f.code == REG_ARRANGE) ? 40'(bad_arr) :
                        (f.code == REG_STATUS) ? 40'(1) << f.idx : mem[{f.idx, f.code}];
               end
               if (!f.rd) begin
                  wr_cnt++;
                  for (int k = 1; k < 4; k++)
                     if (f.idx == BCAST_IDX || f.idx == k)
                        mem[{k[6:0], f.code}] = f.data;
               end
               // Hold last reply bit past the sync delay of the reader
               #50 dat_oe = 1'b0;
            end
            @(negedge rst_b) dat_oe = 1'b0;
         join_any
         disable fork;
      end
   end
endmodule

// >>> sbc_top_tb.sv
// Self-checking testbench for the stack back-channel coordinator
`timescale 1ns/10ps
module sbc_top_tb import sbc_pkg::*; ;
   logic clk_sys = 1'b0, rst_b = 1'b0, host_cmd_valid = 1'b0, role_follower_in = 1'b0;
   logic straps_settled_in = 1'b1, strap_mismatch_in = 1'b0, sync_fault_in = 1'b0;
   logic sync_stuck_in = 1'b0, vout_ok_in = 1'b1, bad_arr = 1'b0, f_o, f_oe;
   sbc_hcmd_t host_cmd = '0;
   logic host_cmd_ready, host_rsp_valid, backchannel_clock_o, backchannel_clock_oe, backchannel_data_o;
   logic backchannel_data_oe, switch_enable, current_share_line_pull_low, power_good_output;
   logic alert_pin_o, alert_pin_oe, strap_mismatch_fault, por_fault;
   logic [DATA_W-1:0] host_rsp_data, last_q;
   int err_count = 0, tests_run = 0;
   // Pull-ups on both link lines when nobody drives
   wire bc_clk = backchannel_clock_oe ? backchannel_clock_o : 1'b1;
   wire backchannel_data_i = backchannel_data_oe ? backchannel_data_o : f_oe ? f_o : 1'b1;
   sbc_top #(.POLL_CYC(200)) dut_u (.*);
   sbc_fol_model fol_u (.bc_clk, .bc_line(backchannel_data_i), .rst_b, .bad_arr, .dat_o(f_o), .dat_oe(f_oe));
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   // ---------
   // Helpers
   // ---------
   task automatic chk(input logic [DATA_W-1:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (err_count == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Bounded wait; running out counts a mismatch and ends the run
   task automatic wait_hi(ref logic s, input int n);
      int k;
      for (k = 0; k < n && s !== 1'b1; k++)
         @(posedge clk_sys);
      if (k == n) begin
         chk(1'b0, 1'b1);
         tally_and_finish();
      end
   endtask
   task automatic wait_wr(input int n);
      int k;
      for (k = 0; k < 20000 && fol_u.wr_cnt < n; k++)
         @(posedge clk_sys);
      chk(40'(fol_u.wr_cnt), 40'(n));
      if (k == 20000)
         tally_and_finish();
   endtask
   // Request held until taken; a read also waits for its answer
   task automatic host_op(input logic wr, input logic [7:0] c, input logic [DATA_W-1:0] d);
      @(posedge clk_sys);
      host_cmd <= '{wr, c, d};
      host_cmd_valid <= 1'b1;
      @(posedge clk_sys);
      wait_hi(host_cmd_ready, 30000);
      host_cmd_valid <= 1'b0;
      if (!wr) begin
         @(posedge clk_sys);
         wait_hi(host_rsp_valid, 30000);
         last_q = host_rsp_data;
      end
   endtask
   task automatic rd(input logic [7:0] c, input logic [DATA_W-1:0] exp);
      host_op(1'b0, c, '0);
      chk(last_q, exp);
   endtask
   task automatic boot(input logic fol, mis, bad);
      @(posedge clk_sys);
      rst_b <= 1'b0;
      role_follower_in <= fol;
      strap_mismatch_in <= mis;
      bad_arr <= bad;
      sync_fault_in <= 1'b0;
      sync_stuck_in <= 1'b0;
      repeat (20) @(posedge clk_sys);
      rst_b <= 1'b1;
   endtask
   // -----------
   // Scenarios
   // -----------
   task automatic t_boot();
      boot(1'b0, 1'b0, 1'b0);
      wait_wr(12);
      chk({por_fault, alert_pin_oe}, 2'b00);
      rd(REG_PHASE, 40'hff);
   endtask
   task automatic t_bcast();
      host_op(1'b1, REG_VOUT, 40'h1234);
      wait_wr(13);
      chk(fol_u.mem[{7'd3, REG_VOUT}], 40'h1234);
      rd(REG_VOUT, 40'h1234);
   endtask
   task automatic t_queue();
      host_op(1'b1, REG_PHASE, 40'h2);
      rd(REG_ORDER, 40'h2);
      host_op(1'b1, REG_FREQ, 40'haa);
      host_op(1'b1, REG_FREQ, 40'hbb);
      host_op(1'b1, REG_FREQ, 40'hcc);
      host_op(1'b0, REG_FREQ, '0);
      chk(40'(last_q === 40'hcc), '0);
      wait_wr(16);
      rd(REG_FREQ, 40'hcc);
   endtask
   task automatic t_poll();
      host_op(1'b1, REG_PHASE, 40'hff);
      // Room for at least one full poll round
      repeat (3000) @(posedge clk_sys);
      rd(REG_STATUS, 40'he);
   endtask
   task automatic t_sync();
      sync_fault_in <= 1'b1;
      sync_stuck_in <= 1'b1;
      repeat (10) @(posedge clk_sys);
      chk({switch_enable, power_good_output, alert_pin_oe, current_share_line_pull_low}, 4'b1100);
   endtask
   task automatic t_follower();
      boot(1'b1, 1'b0, 1'b0);
      repeat (30) @(posedge clk_sys);
      sync_stuck_in <= 1'b1;
      host_cmd_valid <= 1'b1;
      wait_hi(current_share_line_pull_low, 200);
      chk({switch_enable, power_good_output, host_cmd_ready}, 3'b000);
      host_cmd_valid <= 1'b0;
   endtask
   task automatic t_strap();
      boot(1'b0, 1'b1, 1'b0);
      wait_hi(strap_mismatch_fault, 200);
      // Power outputs register the latched fault one edge later
      @(posedge clk_sys);
      chk({switch_enable, current_share_line_pull_low, power_good_output, alert_pin_oe}, 4'b0100);
   endtask
   task automatic t_por();
      boot(1'b0, 1'b0, 1'b1);
      wait_hi(por_fault, 20000);
      // Alert enable follows the latched fault one edge later
      @(posedge clk_sys);
      chk({switch_enable, alert_pin_oe, alert_pin_o}, 3'b010);
   endtask
   initial begin
      t_boot();
      t_bcast();
      t_queue();
      t_poll();
      t_sync();
      t_follower();
      t_strap();
      t_por();
      tally_and_finish();
   end
endmodule
